// *** rtl/pfc_defs.vh ***
// Constants for the parallel flash host controller
`ifndef PFC_DEFS_VH
`define PFC_DEFS_VH
`define PFC_ADDR_W 18
`define PFC_DATA_W 8
`define PFC_CMD_ADDR1 18'h00555
`define PFC_CMD_ADDR2 18'h002aa
`define PFC_CMD_UNLOCK1 8'haa
`define PFC_CMD_UNLOCK2 8'h55
`define PFC_CMD_PROGRAM 8'ha0
`define PFC_CMD_ERASE 8'h80
`define PFC_CMD_CHIP_ERASE 8'h10
`define PFC_CMD_BLOCK_ERASE 8'h30
`define PFC_CMD_ID_ENTRY 8'h90
`define PFC_CMD_ID_EXIT 8'hf0
`define PFC_CMD_LOCKOUT 8'h40
`define PFC_OP_READ 3'h0
`define PFC_OP_PROGRAM 3'h1
`define PFC_OP_CHIP_ERASE 3'h2
`define PFC_OP_BLOCK_ERASE 3'h3
`define PFC_OP_ID_ENTRY 3'h4
`define PFC_OP_ID_EXIT 3'h5
`define PFC_OP_LOCKOUT 3'h6
`define PFC_OP_LOCK_QUERY 3'h7
`define PFC_POLL_BIT 7
`define PFC_TOGGLE_BIT 6
`define PFC_LOCK_BIT 0
`define PFC_ACCESS_NS 90
`define PFC_CLK_NS 40
`define PFC_ACCESS_CYC ((`PFC_ACCESS_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_BOOT_ADDR_TOP 18'h3c000
`define PFC_BOOT_ADDR_BOT 18'h00000
`endif

// *** rtl/pfc_bus_cycle.v ***
// One strobed bus cycle on the flash pins, read or write
`timescale 1ns/1ps
`include "pfc_defs.vh"
module pfc_bus_cycle #(
  parameter STROBE_CYC = `PFC_ACCESS_CYC
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_start,
  input wire i_write,
  input wire [17:0] i_addr,
  input wire [7:0] i_wdata,
  input wire [7:0] i_pin_data,
  output reg o_done,
  output reg [7:0] o_rdata,
  output reg [17:0] o_addr,
  output reg [7:0] o_dq_out,
  output reg o_dq_oe_n,
  output reg o_ce_n,
  output reg o_oe_n,
  output reg o_we_n
);
  localparam S_IDLE = 3'b001;
  localparam S_STROBE = 3'b010;
  localparam S_REL = 3'b100;
  reg [2:0] state_ff;
  reg [7:0] cnt_ff;
  reg wr_ff;
  // Strobe held for the access time, then released for one cycle of recovery
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    if (i_rst) begin
      state_ff <= S_IDLE;
      cnt_ff <= 8'h00;
      wr_ff <= 1'b0;
      o_rdata <= 8'h00;
      o_addr <= 18'h00000;
      o_dq_out <= 8'h00;
      o_dq_oe_n <= 1'b1;
      o_ce_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_we_n <= 1'b1;
    end else begin
      case (state_ff)
        S_IDLE: begin
          if (i_start) begin
            wr_ff <= i_write;
            o_addr <= i_addr;
            o_dq_out <= i_wdata;
            o_dq_oe_n <= ~i_write;
            o_ce_n <= 1'b0; // Select the chip for the access
            o_oe_n <= i_write; // Read: outputs on, write strobe stays high
            o_we_n <= ~i_write;
            cnt_ff <= STROBE_CYC[7:0];
            state_ff <= S_STROBE;
          end
        end
        S_STROBE: begin
          if (cnt_ff <= 8'h01) begin
            // Sample before any strobe moves; data latched on the rising edge
            if (!wr_ff) o_rdata <= i_pin_data;
            o_we_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_ce_n <= 1'b1;
            state_ff <= S_REL;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        S_REL: begin
          // Release the data bus only after the write strobe has risen
          o_dq_oe_n <= 1'b1;
          o_done <= 1'b1;
          state_ff <= S_IDLE;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
endmodule

// *** rtl/pfc_host.v ***
// Host controller that drives a byte-wide parallel flash through its pins
// Overview of operation
// - Host reads with select and output enable low, write strobe high.
// - Host enables lockout with a six-cycle sequence; device sets it.
// - In ID mode host reads boot address, A0 low, A1 high, for lockout.
// - Software ID mode lasts until host issues the exit command.
// - High voltage on the ID address pin enters hardware ID mode.
// - Host enters software ID mode with a three-cycle sequence.
`timescale 1ns/1ps
`include "pfc_defs.vh"
module pfc_host #(
  parameter BOOT_TOP = 1,
  parameter STROBE_CYC = `PFC_ACCESS_CYC,
  parameter POLL_LIMIT = 24'hffffff
) (
  input wire I_CLK,
  input wire I_RST,
  input wire I_REQ,
  input wire [2:0] I_OP,
  input wire [17:0] I_ADDR,
  input wire [7:0] I_WDATA,
  input wire I_HV_ID,
  input wire [7:0] I_DQ_IN,
  output reg O_BUSY,
  output reg O_DONE,
  output reg O_ERR,
  output reg [7:0] O_RDATA,
  output reg O_LOCKED,
  output reg O_HV_ID_ADDR_PIN,
  output wire [17:0] O_ADDR,
  output wire [7:0] O_DQ_OUT,
  output wire O_DQ_OE_N,
  output wire O_CE_N,
  output wire O_OE_N,
  output wire O_WE_N
);
  localparam S_IDLE = 5'b00001;
  localparam S_ISSUE = 5'b00010;
  localparam S_WAIT = 5'b00100;
  localparam S_POLL = 5'b01000;
  localparam S_END = 5'b10000;
  localparam [17:0] BOOT_BASE = BOOT_TOP ? `PFC_BOOT_ADDR_TOP : `PFC_BOOT_ADDR_BOT;
  reg [4:0] state_ff;
  reg [2:0] op_ff;
  reg [17:0] addr_ff;
  reg [7:0] wdata_ff;
  reg [2:0] step_ff;
  reg [2:0] nsteps_ff;
  reg poll_ff;
  reg first_ff;
  reg toggle_ff;
  reg [23:0] tmo_ff;
  reg [7:0] dq_s1_ff;
  reg [7:0] dq_s2_ff;
  reg cyc_start_ff;
  reg cyc_write_ff;
  reg [17:0] cyc_addr_ff;
  reg [7:0] cyc_wdata_ff;
  wire cyc_done;
  wire [7:0] cyc_rdata;
  reg [17:0] step_addr;
  reg [7:0] step_data;
  reg step_write;
  // Pin data passes two flops; the first is read only by the second
  always @(posedge I_CLK) begin
    if (I_RST) begin
      dq_s1_ff <= 8'h00;
      dq_s2_ff <= 8'h00;
    end else begin
      dq_s1_ff <= I_DQ_IN;
      dq_s2_ff <= dq_s1_ff;
    end
  end
  // Pin sequencing lives in the cycle engine
  pfc_bus_cycle #(.STROBE_CYC(STROBE_CYC + 2)) u_cyc (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_start(cyc_start_ff),
    .i_write(cyc_write_ff),
    .i_addr(cyc_addr_ff),
    .i_wdata(cyc_wdata_ff),
    .i_pin_data(dq_s2_ff),
    .o_done(cyc_done),
    .o_rdata(cyc_rdata),
    .o_addr(O_ADDR),
    .o_dq_out(O_DQ_OUT),
    .o_dq_oe_n(O_DQ_OE_N),
    .o_ce_n(O_CE_N),
    .o_oe_n(O_OE_N),
    .o_we_n(O_WE_N)
  );
  // Address and data of each step of the unlock sequences
  always @* begin
    step_write = 1'b1;
    step_addr = (step_ff == 3'd1 || step_ff == 3'd4) ? `PFC_CMD_ADDR2 : `PFC_CMD_ADDR1;
    step_data = (step_ff == 3'd1 || step_ff == 3'd4) ? `PFC_CMD_UNLOCK2 : `PFC_CMD_UNLOCK1;
    if (step_ff == 3'd2) begin
      case (op_ff)
        `PFC_OP_PROGRAM: step_data = `PFC_CMD_PROGRAM;
        `PFC_OP_ID_ENTRY: step_data = `PFC_CMD_ID_ENTRY;
        `PFC_OP_ID_EXIT: step_data = `PFC_CMD_ID_EXIT;
        default: step_data = `PFC_CMD_ERASE;
      endcase
    end
    if (step_ff == 3'd3 && op_ff == `PFC_OP_PROGRAM) begin
      step_addr = addr_ff;
      step_data = wdata_ff;
    end
    if (step_ff == 3'd5) begin
      case (op_ff)
        `PFC_OP_CHIP_ERASE: step_data = `PFC_CMD_CHIP_ERASE;
        `PFC_OP_BLOCK_ERASE: begin
          step_addr = addr_ff; // Block address selects the one block
          step_data = `PFC_CMD_BLOCK_ERASE;
        end
        default: step_data = `PFC_CMD_LOCKOUT;
      endcase
    end
    if (op_ff == `PFC_OP_READ) begin
      step_write = 1'b0;
      step_addr = addr_ff;
    end
    if (op_ff == `PFC_OP_LOCK_QUERY) begin
      step_write = 1'b0;
      step_addr = {BOOT_BASE[17:2], 2'b10}; // A1 high, A0 low
    end
  end
  // Operation sequencer with completion polling
  always @(posedge I_CLK) begin
    cyc_start_ff <= 1'b0;
    O_DONE <= 1'b0;
    if (I_RST) begin
      state_ff <= S_IDLE;
      op_ff <= `PFC_OP_READ;
      addr_ff <= 18'h00000;
      wdata_ff <= 8'h00;
      step_ff <= 3'd0;
      nsteps_ff <= 3'd1;
      poll_ff <= 1'b0;
      first_ff <= 1'b0;
      toggle_ff <= 1'b0;
      tmo_ff <= 24'h000000;
      cyc_write_ff <= 1'b0;
      cyc_addr_ff <= 18'h00000;
      cyc_wdata_ff <= 8'h00;
      O_BUSY <= 1'b0;
      O_ERR <= 1'b0;
      O_RDATA <= 8'h00;
      O_LOCKED <= 1'b0;
      O_HV_ID_ADDR_PIN <= 1'b0;
    end else begin
      O_HV_ID_ADDR_PIN <= I_HV_ID; // Programmer-style ID entry
      case (state_ff)
        S_IDLE: begin
          if (I_REQ) begin
            op_ff <= I_OP;
            addr_ff <= I_ADDR;
            wdata_ff <= I_WDATA;
            step_ff <= 3'd0;
            O_BUSY <= 1'b1;
            O_ERR <= 1'b0;
            case (I_OP)
              `PFC_OP_PROGRAM: nsteps_ff <= 3'd4;
              `PFC_OP_CHIP_ERASE, `PFC_OP_BLOCK_ERASE, `PFC_OP_LOCKOUT: nsteps_ff <= 3'd6;
              `PFC_OP_ID_ENTRY, `PFC_OP_ID_EXIT: nsteps_ff <= 3'd3;
              default: nsteps_ff <= 3'd1;
            endcase
            // Only program, erase and lockout need completion polling
            poll_ff <= (I_OP == `PFC_OP_PROGRAM) || (I_OP == `PFC_OP_CHIP_ERASE) ||
                       (I_OP == `PFC_OP_BLOCK_ERASE) || (I_OP == `PFC_OP_LOCKOUT);
            state_ff <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          cyc_start_ff <= 1'b1;
          cyc_write_ff <= step_write;
          cyc_addr_ff <= step_addr;
          cyc_wdata_ff <= step_data;
          state_ff <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc_done) begin
            if (step_ff + 3'd1 < nsteps_ff) begin
              step_ff <= step_ff + 3'd1;
              state_ff <= S_ISSUE;
            end else if (poll_ff) begin
              first_ff <= 1'b1;
              tmo_ff <= 24'h000000;
              cyc_start_ff <= 1'b1; // Status read at the target address
              cyc_write_ff <= 1'b0;
              cyc_addr_ff <= addr_ff;
              state_ff <= S_POLL;
            end else begin
              O_RDATA <= cyc_rdata;
              if (op_ff == `PFC_OP_LOCK_QUERY)
                O_LOCKED <= cyc_rdata[`PFC_LOCK_BIT]; // One means protected
              state_ff <= S_END;
            end
          end
        end
        S_POLL: begin
          if (cyc_done) begin
            toggle_ff <= cyc_rdata[`PFC_TOGGLE_BIT];
            tmo_ff <= tmo_ff + 24'h000001;
            // Done once two reads agree on the toggle bit
            if (!first_ff && toggle_ff == cyc_rdata[`PFC_TOGGLE_BIT]) begin
              O_RDATA <= cyc_rdata;
              // Program must read back the true DQ7 bit; refused boot writes show here
              if (op_ff == `PFC_OP_PROGRAM &&
                  cyc_rdata[`PFC_POLL_BIT] != wdata_ff[`PFC_POLL_BIT])
                O_ERR <= 1'b1; // Lockout refusal is reported
              if (op_ff == `PFC_OP_LOCKOUT)
                O_LOCKED <= 1'b1;
              state_ff <= S_END;
            end else if (tmo_ff == POLL_LIMIT) begin
              O_ERR <= 1'b1; // Stuck device: give up rather than hang
              state_ff <= S_END;
            end else begin
              first_ff <= 1'b0;
              cyc_start_ff <= 1'b1;
            end
          end
        end
        S_END: begin
          O_BUSY <= 1'b0;
          O_DONE <= 1'b1;
          state_ff <= S_IDLE;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
endmodule

// *** bench/pfc_host_monitor.sv ***
// Pin-level checks on the flash host controller
`timescale 1ns/1ps
module pfc_host_monitor (
  input wire I_CLK,
  input wire I_RST,
  input wire I_REQ,
  input wire [2:0] I_OP,
  input wire I_HV_ID,
  input wire O_BUSY,
  input wire O_DONE,
  input wire O_HV_ID_ADDR_PIN,
  input wire [17:0] O_ADDR,
  input wire O_DQ_OE_N,
  input wire O_CE_N,
  input wire O_OE_N,
  input wire O_WE_N
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  // Strobes never overlap, so the data pins are never fought over
  property p_rd_pins; !O_OE_N |-> !O_CE_N && O_WE_N && O_DQ_OE_N; endproperty
  a_rd_pins: assert property (p_rd_pins) else $error("bad read strobes");
  property p_wr_pins; !O_WE_N |-> !O_CE_N && O_OE_N && !O_DQ_OE_N; endproperty
  a_wr_pins: assert property (p_wr_pins) else $error("bad write strobes");
  // Write pulse covers the access time, address held meanwhile
  sequence s_wr_low; (!O_WE_N)[*3]; endsequence
  property p_wr_width; $fell(O_WE_N) |-> s_wr_low; endproperty
  a_wr_width: assert property (p_wr_width) else $error("short write pulse");
  property p_addr_hold; !O_WE_N && !$past(O_WE_N) |-> $stable(O_ADDR); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");
  // Host lets go of the data pins one cycle after the write ends
  property p_dq_free; $rose(O_WE_N) |=> O_DQ_OE_N; endproperty
  a_dq_free: assert property (p_dq_free) else $error("data pins held");
  property p_idle; !O_BUSY && !O_DONE |-> O_CE_N; endproperty
  a_idle: assert property (p_idle) else $error("select while idle");
  property p_take; I_REQ && !O_BUSY && !O_DONE |=> O_BUSY; endproperty
  a_take: assert property (p_take) else $error("request not taken");
  property p_rd_time; I_REQ && !O_BUSY && !O_DONE && I_OP == 3'h0 |-> ##[2:40] O_DONE; endproperty
  a_rd_time: assert property (p_rd_time) else $error("read too slow");
  property p_hv; $rose(I_HV_ID) |-> ##[1:2] O_HV_ID_ADDR_PIN; endproperty
  a_hv: assert property (p_hv) else $error("id pin not raised");
endmodule

// *** bench/pfc_flash_model.sv ***
// Behavioural byte-wide flash device facing the host controller
`timescale 1ns/1ps
module pfc_flash_model #(
  parameter BOOT_TOP = 1,
  parameter OP_NS = 3000,
  parameter MFR_ID = 8'h5a, // Arbitrary value
  parameter DEV_ID = 8'h3c // Arbitrary value
) (
  input wire [17:0] i_addr,
  input wire [7:0] i_dq,
  input wire i_ce_n,
  input wire i_oe_n,
  input wire i_we_n,
  input wire i_hv,
  output wire [7:0] o_dq
);
  reg [7:0] mem [0:262143];
  reg [7:0] rd, flt, d, last;
  reg [17:0] la;
  reg [2:0] step, nx;
  reg idm, lock, busy, er, tog;
  integer i;
  event go;
  wire wr = i_ce_n | i_we_n;
  wire en = !i_ce_n && !i_oe_n && i_we_n;
  // Block number, 0 is boot; the bottom variant mirrors the map
  function [2:0] blk(input [17:0] a);
    reg [17:0] b;
    begin
      b = BOOT_TOP ? a : ~a;
      blk = b >= 18'h3c000 ? 0 : b >= 18'h3a000 ? 1 : b >= 18'h38000 ? 2 : b >= 18'h20000 ? 3 : 4;
    end
  endfunction
  initial begin
    for (i = 0; i < 262144; i = i + 1) mem[i] = 8'hff;
    {step, idm, lock, busy, tog, flt} = 0;
  end
  // Released pins show the inverse of the last byte, not a stale copy
  assign o_dq = en ? rd : flt;
  always @* begin
    if (busy) rd = {er ? 1'b0 : ~last[7], tog, 6'h00};
    else if (idm || i_hv) rd = (i_addr[1:0] == 2'b10 && blk(i_addr) == 0) ? {7'h00, lock}
      : i_addr[0] ? DEV_ID : MFR_ID;
    else rd = mem[i_addr];
    if (en) flt = ~rd;
  end
  // Settle first: the host moves address and strobe on the same edge
  always @(negedge wr) #1 la = i_addr;
  always @(negedge (i_ce_n | i_oe_n)) if (busy) tog = ~tog;
  // Self-timed program or erase; commands are ignored meanwhile
  always @(go) begin
    busy = 1;
    #OP_NS busy = 0;
  end
  // Command decoder; a wrong byte drops back, but may open a new sequence
  always @(posedge wr) if (!busy) begin
    d = i_dq;
    nx = (la == 18'h00555 && d == 8'haa) ? 3'd1 : 3'd0;
    case (step)
      1: if (la == 18'h002aa && d == 8'h55) nx = 2;
      2: if (la == 18'h00555 && d == 8'ha0) nx = 3;
        else if (la == 18'h00555 && d == 8'h80) nx = 4;
        else if (la == 18'h00555 && d == 8'h90) idm = 1;
        else if (la == 18'h00555 && d == 8'hf0) idm = 0;
      3: begin
        nx = 0;
        er = 0;
        last = d;
        if (!(lock && blk(la) == 0)) begin
          mem[la] = mem[la] & d;
          -> go;
        end
      end
      4: if (la == 18'h00555 && d == 8'haa) nx = 5;
      5: if (la == 18'h002aa && d == 8'h55) nx = 6;
      6: begin
        nx = 0;
        if (la == 18'h00555 && d == 8'h40) lock = 1;
        else if (d == 8'h10 || (d == 8'h30 && !(lock && blk(la) == 0))) begin
          for (i = 0; i < 262144; i = i + 1)
            if ((d == 8'h10 || blk(i) == blk(la)) && !(lock && blk(i) == 0)) mem[i] = 8'hff;
          er = 1;
          -> go;
        end
      end
      default: ;
    endcase
    step = nx;
  end
endmodule

// *** bench/pfc_host_tb.sv ***
// Self-checking bench: flash host controller against a device model
`timescale 1ns/1ps
module pfc_host_tb;
  logic I_CLK, I_RST, I_REQ, I_HV_ID;
  logic [2:0] I_OP;
  logic [17:0] I_ADDR;
  logic [7:0] I_WDATA;
  wire [7:0] fl_dq, O_RDATA, O_DQ_OUT;
  wire [17:0] O_ADDR;
  wire O_BUSY, O_DONE, O_ERR, O_LOCKED, O_HV_ID_ADDR_PIN, O_DQ_OE_N, O_CE_N, O_OE_N, O_WE_N;
  integer n_fail = 0, num_checks = 0, cyc = 0, i, n;
  // Row: op, address, write byte, expected read byte, expected error
  logic [43:0] rows [0:27];
  // The pins carry the host's byte while it drives them, else the device's
  wire [7:0] I_DQ_IN = O_DQ_OE_N ? fl_dq : O_DQ_OUT;
  pfc_host #(.BOOT_TOP(1), .POLL_LIMIT(24'h000040)) uut (.*);
  pfc_flash_model #(.BOOT_TOP(1)) dev (.i_addr(O_ADDR), .i_dq(I_DQ_IN), .i_ce_n(O_CE_N),
    .i_oe_n(O_OE_N), .i_we_n(O_WE_N), .i_hv(O_HV_ID_ADDR_PIN), .o_dq(fl_dq));
  initial begin
    I_CLK = 0;
    forever #20 I_CLK = ~I_CLK;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task summarize;
    if (n_fail == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Cut a hung run short
  always @(posedge I_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize;
    end
  end
  // One request, then a bounded wait for completion and an idle edge
  task op(input logic [2:0] c, input logic [17:0] a, input logic [7:0] d);
    {I_REQ, I_OP, I_ADDR, I_WDATA} = {1'b1, c, a, d};
    @(posedge I_CLK) #1;
    I_REQ = 0;
    for (n = 0; n < 3000 && O_DONE !== 1'b1; n++) @(posedge I_CLK) #1;
    chk(O_DONE, 1'b1);
    @(posedge I_CLK) #1;
  endtask
  initial begin
    {I_RST, I_REQ, I_HV_ID, I_OP, I_ADDR, I_WDATA} = {3'b100, 29'h0};
    rows = '{44'h4_00000_00_00_0, 44'h7_3c000_00_00_0, 44'h5_00000_00_00_0,
      44'h1_01234_a5_00_0, 44'h0_01234_00_a5_0, 44'h1_01234_0f_00_0,
      44'h0_01234_00_05_0, 44'h3_00000_00_00_0, 44'h0_01234_00_ff_0,
      44'h1_3c010_12_00_0, 44'h1_38000_34_00_0, 44'h6_00000_00_01_0,
      44'h1_3c020_56_00_1, 44'h1_20000_78_00_0, 44'h3_3c000_00_00_0,
      44'h0_3c010_00_12_0, 44'h3_38000_00_00_0, 44'h0_38000_00_ff_0,
      44'h0_20000_00_78_0, 44'h4_00000_00_00_0, 44'h7_3c000_00_01_0,
      44'h0_3c000_00_5a_0, 44'h0_3c001_00_3c_0, 44'h5_00000_00_00_0,
      44'h0_3c010_00_12_0, 44'h2_00000_00_00_0, 44'h0_20000_00_ff_0,
      44'h0_3c010_00_12_0};
    repeat (5) @(posedge I_CLK);
    #1 I_RST = 0;
    chk({O_BUSY, O_DONE, O_ERR, O_LOCKED, O_CE_N, O_OE_N, O_WE_N, O_DQ_OE_N}, 8'h0f);
    for (i = 0; i < 28; i++) begin
      op(rows[i][42:40], rows[i][37:20], rows[i][19:12]);
      chk(O_ERR, rows[i][0]);
      if (rows[i][42:40] == 3'h0) chk(O_RDATA, rows[i][11:4]);
      if (rows[i][42:40] >= 3'h6) chk(O_LOCKED, rows[i][4]);
    end
    // Hardware identification through the high-voltage address pin
    I_HV_ID = 1;
    repeat (2) @(posedge I_CLK) #1;
    chk(O_HV_ID_ADDR_PIN, 1'b1);
    op(3'h0, 18'h3c000, 8'h00);
    chk(O_RDATA, 8'h5a);
    I_HV_ID = 0;
    // Reset in mid-sequence leaves the device holding a partial command
    {I_REQ, I_OP, I_ADDR, I_WDATA} = {1'b1, 3'h1, 18'h01300, 8'h11};
    @(posedge I_CLK) #1;
    I_REQ = 0;
    repeat (8) @(posedge I_CLK) #1;
    I_RST = 1;
    repeat (2) @(posedge I_CLK) #1;
    chk({O_BUSY, O_CE_N, O_WE_N, O_DQ_OE_N}, 4'h7);
    I_RST = 0;
    op(3'h1, 18'h01300, 8'h11);
    op(3'h0, 18'h01300, 8'h00);
    chk(O_RDATA, 8'h11);
    summarize;
  end
endmodule
bind pfc_host pfc_host_monitor u_mon (.*);
